/* File: spimp_defines.svh */
// register offsets, field positions and timing constants of the serial port
`ifndef SPIMP_DEFINES_SVH
`define SPIMP_DEFINES_SVH
`define SPIMP_OFS_DATA     8'hf0
`define SPIMP_OFS_CTRL     8'hf1
`define SPIMP_OFS_STAT     8'hf2
`define SPIMP_OFS_PRSC     8'hf3
`define SPIMP_RST_BYTE     8'h00
`define SPIMP_BIT_IE       7
`define SPIMP_BIT_OE       6
`define SPIMP_BIT_ISRC     5
`define SPIMP_BIT_ROLE     4
`define SPIMP_BIT_CLOCK_IDLE_LEVEL     3
`define SPIMP_BIT_CAPTURE_EDGE_SELECT     2
`define SPIMP_BIT_DONE     7
`define SPIMP_BIT_WRITE_COLLISION_FLAG     6
`define SPIMP_BIT_MASTER_FAULT_FLAG     4
`define SPIMP_BIT_HALF_DIVIDER_ENABLE     4
`define SPIMP_PRSC_MASK    8'h17
`define SPIMP_STAT_MASK    8'hd0
`define SPIMP_DIV_2        6'h02
`define SPIMP_DIV_4        6'h04
`define SPIMP_DIV_16       6'h10
`define SPIMP_DIV_32       6'h20
`define SPIMP_BITS         4'h8
`endif

/* File: spimp_pkg.sv */
// types shared by the serial port files
package spimp_pkg;
  typedef struct packed {
    logic       ie;
    logic       oe;
    logic       isrc;
    logic       role;
    logic       clock_idle_level;
    logic       capture_edge_select;
    logic [1:0] rate;
  } spimp_ctrl_t;

  typedef struct packed {
    logic i;
    logic o;
    logic oe;
  } spimp_pin_t;

  typedef enum logic [2:0] {
    SPIMP_IDLE = 3'b001,
    SPIMP_LEAD = 3'b010,
    SPIMP_TRAIL = 3'b100
  } spimp_state_t;
endpackage

/* File: spimp_rate_gen.sv */
// master bit-rate enable generator
`timescale 1ns/1ps
`include "spimp_defines.svh"
module spimp_rate_gen (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       run,
  input  wire logic [1:0] rate_sel,
  input  wire logic [2:0] prescale,
  input  wire logic       half_div_off,
  // output
  output logic            tick
);
  logic [5:0]  rate_div;
  logic [10:0] limit;
  logic [10:0] cnt_r;
  logic [10:0] cnt_nxt;

  always_comb begin
    case (rate_sel)
      2'b00:   rate_div = `SPIMP_DIV_2;
      2'b01:   rate_div = `SPIMP_DIV_4;
      2'b10:   rate_div = `SPIMP_DIV_16;
      default: rate_div = `SPIMP_DIV_32;
    endcase
  end

  // one tick per half serial clock period, n1*n2*n3/2 cycles
  assign limit = 11'((({8'h0, prescale} + 11'h1) * {5'h0, rate_div}
                      * (half_div_off ? 11'h1 : 11'h2)) >> 1) - 11'h1;
  assign cnt_nxt = (cnt_r >= limit) ? 11'h0 : cnt_r + 11'h1;
  assign tick = run && (cnt_r >= limit);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 11'h0;
    end else if (!run) begin
      cnt_r <= 11'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

/* File: spimp_shifter.sv */
// eight-bit exchange shift register, msb first
`timescale 1ns/1ps
`include "spimp_defines.svh"
module spimp_shifter (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  input  wire logic       sample,
  input  wire logic       shift,
  input  wire logic       din,
  // state
  output logic [7:0]      sreg,
  output logic            dout
);
  logic [7:0] sreg_r;
  logic       cap_r;

  assign sreg = sreg_r;
  assign dout = sreg_r[7];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sreg_r <= `SPIMP_RST_BYTE;
      cap_r  <= 1'b0;
    end else if (load) begin
      sreg_r <= load_val;
    end else begin
      if (sample) begin
        cap_r <= din;
      end
      if (shift) begin
        sreg_r <= {sreg_r[6:0], sample ? din : cap_r};
      end
    end
  end
endmodule

/* File: spimp_top.sv */
// serial peripheral port, master or slave, on a classic wishbone slave
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`include "spimp_defines.svh"
// Contract
// - after done sets, later received bytes are dropped until done clears
// - no flag reports the lost-byte overrun
// - interrupt request when done or fault sets while the other is clear
// - source select routes external pin or port request to the channel
// - as master only a data write starts a byte
// - received byte copied to a read buffer when done sets
// - data write loads the shift register directly
// - output enable gates pin drive; cleared on master fault
// - role bit picks master or slave; cleared on master fault
// - polarity bit sets the clock idle level
// - phase bit picks first or second edge to capture
// - rate bits divide by 2, 4, 16, 32 in master role only
// - done flag clears on status read then data access
// - data writes ignored while done is set
// - collision flag on data write during transfer, no interrupt
// - untouched slave shifts out its last received byte
// - fault flag sets on select low as master; clears by status read, control write
// - master clock is internal clock over prescale, rate and half divider
// - eight clock pulses exchange one byte each way, msb first
module spimp_top (
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // serial pins
  input  wire logic        SCK_I,
  output logic             SCK_O,
  output logic             SCK_OE,
  input  wire logic        MOSI_I,
  output logic             MOSI_O,
  output logic             MOSI_OE,
  input  wire logic        MISO_I,
  output logic             MISO_O,
  output logic             MISO_OE,
  input  wire logic        SS_N,
  // shared interrupt channel
  input  wire logic        EXT_IRQ_I,
  output logic             IRQ_CHANNEL
);
  spimp_pkg::spimp_ctrl_t  ctrl_r;
  spimp_pkg::spimp_state_t state_r;
  logic [7:0] prsc_r;
  logic [7:0] rbuf_r;
  logic       done_r;
  logic       write_collision_flag_r;
  logic       master_fault_flag_r;
  logic       done_seen_r;
  logic       write_collision_flag_seen_r;
  logic       master_fault_flag_seen_r;
  logic       bit_r;
  logic       req_r;
  logic [3:0] edge_cnt_r;
  logic       sck_r;
  logic       sck_in_r;
  logic       ss_r;
  logic       ack_r;
  logic [31:0] dat_r;
  logic       irq_r;
  logic       sck_o_r;
  logic       sck_oe_r;
  logic       mosi_o_r;
  logic       mosi_oe_r;
  logic       miso_o_r;
  logic       miso_oe_r;

  logic       acc;
  logic       wr_byte0;
  logic       wr_data;
  logic       rd_data;
  logic       wr_ctrl;
  logic       rd_stat;
  logic       wr_prsc;
  logic       master;
  logic       busy;
  logic       tick;
  logic       lead_edge;
  logic       trail_edge;
  logic       slv_lead;
  logic       slv_trail;
  logic       mst_lead;
  logic       mst_trail;
  logic       sample;
  logic       shift;
  logic       last_edge;
  logic       load_ok;
  logic       fault;
  logic       din;
  logic       dout;
  logic [7:0] sreg;
  logic [7:0] rd_mux;
  logic [7:0] ctrl_w;
  logic       req_nxt;

  // bus decode, one access per request, ack after one wait cycle
  assign acc      = WB_CYC_I && WB_STB_I && !ack_r;
  assign wr_byte0 = acc && WB_WE_I && WB_SEL_I[0];
  assign wr_data  = wr_byte0 && (WB_ADR_I == `SPIMP_OFS_DATA);
  assign wr_ctrl  = wr_byte0 && (WB_ADR_I == `SPIMP_OFS_CTRL);
  assign wr_prsc  = wr_byte0 && (WB_ADR_I == `SPIMP_OFS_PRSC);
  assign rd_data  = acc && !WB_WE_I && (WB_ADR_I == `SPIMP_OFS_DATA);
  assign rd_stat  = acc && !WB_WE_I && (WB_ADR_I == `SPIMP_OFS_STAT);

  assign master = ctrl_r.role;
  assign busy   = (state_r != spimp_pkg::SPIMP_IDLE) || (!master && !ss_r);
  assign fault  = master && !ss_r;

  // slave edges on the sampled clock, master edges from the rate ticks
  assign slv_lead  = !master && !ss_r && (sck_in_r != sck_r) && (sck_in_r != ctrl_r.clock_idle_level);
  assign slv_trail = !master && !ss_r && (sck_in_r != sck_r) && (sck_in_r == ctrl_r.clock_idle_level);
  assign mst_lead  = master && tick && (state_r == spimp_pkg::SPIMP_LEAD);
  assign mst_trail = master && tick && (state_r == spimp_pkg::SPIMP_TRAIL);
  assign lead_edge  = slv_lead || mst_lead;
  assign trail_edge = slv_trail || mst_trail;
  assign sample = ctrl_r.capture_edge_select ? trail_edge : lead_edge;
  assign shift  = ctrl_r.capture_edge_select ? (lead_edge && edge_cnt_r != 4'h0) : trail_edge;
  assign last_edge = trail_edge && (edge_cnt_r == (`SPIMP_BITS - 4'h1));
  assign load_ok = wr_data && !done_r && !busy;

  assign din = master ? MISO_I : MOSI_I;

  spimp_rate_gen u_rate (
    .clk          (REF_CLK),
    .rst_n        (RST_N),
    .run          (master && state_r != spimp_pkg::SPIMP_IDLE),
    .rate_sel     (ctrl_r.rate),
    .prescale     (prsc_r[2:0]),
    .half_div_off (prsc_r[`SPIMP_BIT_HALF_DIVIDER_ENABLE]),
    .tick         (tick)
  );

  spimp_shifter u_shift (
    .clk      (REF_CLK),
    .rst_n    (RST_N),
    .load     (load_ok),
    .load_val (WB_DAT_I[7:0]),
    .sample   (sample),
    .shift    (shift || (ctrl_r.capture_edge_select && last_edge)),
    .din      (din),
    .sreg     (sreg),
    .dout     (dout)
  );

  // pin and clock samplers
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sck_r    <= 1'b0;
      sck_in_r <= 1'b0;
      ss_r     <= 1'b1;
    end else begin
      sck_in_r <= SCK_I;
      sck_r    <= sck_in_r;
      ss_r     <= SS_N;
    end
  end

  // transfer sequencer and edge counter
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r    <= spimp_pkg::SPIMP_IDLE;
      edge_cnt_r <= 4'h0;
      sck_o_r    <= 1'b0;
    end else begin
      if (fault) begin
        state_r    <= spimp_pkg::SPIMP_IDLE;
        edge_cnt_r <= 4'h0;
      end else if (master) begin
        case (state_r)
          spimp_pkg::SPIMP_IDLE: begin
            if (load_ok) begin
              state_r    <= spimp_pkg::SPIMP_LEAD;
              edge_cnt_r <= 4'h0;
            end
          end
          spimp_pkg::SPIMP_LEAD: begin
            if (tick) begin
              state_r <= spimp_pkg::SPIMP_TRAIL;
            end
          end
          spimp_pkg::SPIMP_TRAIL: begin
            if (tick) begin
              edge_cnt_r <= edge_cnt_r + 4'h1;
              state_r <= last_edge ? spimp_pkg::SPIMP_IDLE : spimp_pkg::SPIMP_LEAD;
            end
          end
          default: begin
            state_r <= spimp_pkg::SPIMP_IDLE;
          end
        endcase
      end else begin
        state_r <= spimp_pkg::SPIMP_IDLE;
        if (ss_r) begin
          edge_cnt_r <= 4'h0;
        end else if (last_edge) begin
          edge_cnt_r <= 4'h0;
        end else if (trail_edge) begin
          edge_cnt_r <= edge_cnt_r + 4'h1;
        end
      end
      if (master && state_r == spimp_pkg::SPIMP_LEAD && tick) begin
        sck_o_r <= !ctrl_r.clock_idle_level;
      end else if (master && state_r == spimp_pkg::SPIMP_TRAIL && tick) begin
        sck_o_r <= ctrl_r.clock_idle_level;
      end else if (state_r == spimp_pkg::SPIMP_IDLE) begin
        sck_o_r <= ctrl_r.clock_idle_level;
      end
    end
  end

  // done flag, read buffer and collision flag
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      done_r      <= 1'b0;
      done_seen_r <= 1'b0;
      write_collision_flag_r      <= 1'b0;
      write_collision_flag_seen_r <= 1'b0;
      rbuf_r      <= `SPIMP_RST_BYTE;
      bit_r       <= 1'b0;
    end else begin
      if (rd_stat) begin
        done_seen_r <= done_r;
        write_collision_flag_seen_r <= write_collision_flag_r;
      end
      if (sample) begin
        bit_r <= din;
      end
      if (last_edge && !done_r) begin
        done_r <= 1'b1;
        rbuf_r <= {sreg[6:0], sample ? din : bit_r};
      end else if (done_seen_r && (rd_data || wr_data)) begin
        done_r      <= 1'b0;
        done_seen_r <= 1'b0;
      end
      if (wr_data && busy) begin
        write_collision_flag_r <= 1'b1;
      end else if (write_collision_flag_seen_r && (rd_data || wr_data)) begin
        write_collision_flag_r      <= 1'b0;
        write_collision_flag_seen_r <= 1'b0;
      end
    end
  end

  // control, prescaler and master fault
  assign ctrl_w = WB_DAT_I[7:0];
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r      <= spimp_pkg::spimp_ctrl_t'(`SPIMP_RST_BYTE);
      prsc_r      <= `SPIMP_RST_BYTE;
      master_fault_flag_r      <= 1'b0;
      master_fault_flag_seen_r <= 1'b0;
    end else begin
      if (rd_stat) begin
        master_fault_flag_seen_r <= master_fault_flag_r;
      end
      if (wr_ctrl) begin
        ctrl_r <= spimp_pkg::spimp_ctrl_t'(ctrl_w);
        if (master_fault_flag_r && !master_fault_flag_seen_r) begin
          ctrl_r.oe   <= 1'b0;
          ctrl_r.role <= 1'b0;
        end
      end
      if (wr_prsc) begin
        prsc_r <= ctrl_w & `SPIMP_PRSC_MASK;
      end
      if (fault) begin
        master_fault_flag_r      <= 1'b1;
        ctrl_r.oe   <= 1'b0;
        ctrl_r.role <= 1'b0;
      end else if (wr_ctrl && master_fault_flag_seen_r) begin
        master_fault_flag_r      <= 1'b0;
        master_fault_flag_seen_r <= 1'b0;
      end
    end
  end

  // interrupt request on either flag setting while the other is clear
  assign req_nxt = ctrl_r.ie && (done_r ^ master_fault_flag_r);
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      req_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      req_r <= req_nxt;
      irq_r <= ctrl_r.isrc ? req_r : EXT_IRQ_I;
    end
  end

  // pin drivers, slave echoes the last received byte
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sck_oe_r  <= 1'b0;
      mosi_o_r  <= 1'b0;
      mosi_oe_r <= 1'b0;
      miso_o_r  <= 1'b0;
      miso_oe_r <= 1'b0;
    end else begin
      sck_oe_r  <= ctrl_r.oe && master;
      mosi_oe_r <= ctrl_r.oe && master;
      miso_oe_r <= ctrl_r.oe && !master && !ss_r;
      mosi_o_r  <= dout;
      miso_o_r  <= dout;
    end
  end

  // wishbone read data and ack
  always_comb begin
    case (WB_ADR_I)
      `SPIMP_OFS_DATA: rd_mux = rbuf_r;
      `SPIMP_OFS_CTRL: rd_mux = ctrl_r;
      `SPIMP_OFS_STAT: rd_mux = {done_r, write_collision_flag_r, 1'b0, master_fault_flag_r, 4'h0};
      `SPIMP_OFS_PRSC: rd_mux = prsc_r;
      default:         rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= acc;
      dat_r <= acc ? {24'h0, rd_mux} : 32'h0;
    end
  end

  assign WB_ACK_O    = ack_r;
  assign WB_DAT_O    = dat_r;
  assign SCK_O       = sck_o_r;
  assign SCK_OE      = sck_oe_r;
  assign MOSI_O      = mosi_o_r;
  assign MOSI_OE     = mosi_oe_r;
  assign MISO_O      = miso_o_r;
  assign MISO_OE     = miso_oe_r;
  assign IRQ_CHANNEL = irq_r;
endmodule

/* File: spimp_chk.sv */
// checker of the serial port bus reads, pin drive and interrupt channel
`timescale 1ns/1ps
`include "spimp_defines.svh"
module spimp_chk (
  // clock and reset
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  // bus
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  // pins and interrupt
  input wire logic        SCK_O,
  input wire logic        SCK_OE,
  input wire logic        MOSI_OE,
  input wire logic        MISO_OE,
  input wire logic        EXT_IRQ_I,
  input wire logic        IRQ_CHANNEL
);
  logic [7:0]  ctl_r;
  logic [2:0]  hold_r;
  logic [12:0] idle_r;
  wire wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O && WB_SEL_I[0];
  wire wc = wr && WB_ADR_I == `SPIMP_OFS_CTRL;
  wire wd = wr && WB_ADR_I == `SPIMP_OFS_DATA;
  wire settled = hold_r == 3'h7;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // control mirror, cycles since control and data writes
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctl_r <= 8'h00;
      hold_r <= 3'h0;
      idle_r <= 13'h0000;
    end else begin
      if (wc) ctl_r <= WB_DAT_I[7:0];
      hold_r <= wc ? 3'h0 : hold_r + {2'h0, ~&hold_r};
      idle_r <= wd ? 13'h0000 : idle_r + {12'h000, ~&idle_r};
    end
  end
  property p_oe_off;
    settled && !ctl_r[6] |-> !SCK_OE && !MOSI_OE && !MISO_OE;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin driven, enable off");
  property p_master_pins;
    SCK_OE |-> MOSI_OE && !MISO_OE;
  endproperty
  a_master_pins: assert property (p_master_pins) else $error("master pin mix");
  property p_role;
    SCK_OE || MOSI_OE |-> ctl_r[4] || $past(ctl_r[4]);
  endproperty
  a_role: assert property (p_role) else $error("clock driven as slave");
  property p_ext_route;
    settled && !ctl_r[5] |-> IRQ_CHANNEL == $past(EXT_IRQ_I);
  endproperty
  a_ext_route: assert property (p_ext_route) else $error("channel not pin");
  property p_irq_off;
    settled && ctl_r[5] && !ctl_r[7] |-> !IRQ_CHANNEL;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("request while disabled");
  property p_idle_level;
    settled && SCK_OE && idle_r > 13'd5000 |-> SCK_O == ctl_r[3];
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("clock idle level");
  property p_start;
    settled && SCK_OE && $past(SCK_OE) && $changed(SCK_O) |-> idle_r < 13'd5000;
  endproperty
  a_start: assert property (p_start) else $error("clock without data write");
  property p_read_zero;
    WB_ACK_O && !WB_WE_I |-> WB_DAT_O[31:8] == 24'h0
      && (WB_ADR_I != `SPIMP_OFS_STAT || WB_DAT_O[3:0] == 4'h0 && !WB_DAT_O[5])
      && (WB_ADR_I != `SPIMP_OFS_PRSC || WB_DAT_O[7:5] == 3'h0 && !WB_DAT_O[3])
      && (WB_ADR_I[7:2] == 6'h3c || WB_DAT_O == 32'h0);
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("undefined bits set");
  c_data_wr: cover property (wd);
  c_master: cover property ($rose(SCK_OE));
  c_irq: cover property (ctl_r[5] && IRQ_CHANNEL);
endmodule
bind spimp_top spimp_chk chk (
  .REF_CLK     (REF_CLK),
  .RST_N       (RST_N),
  .WB_CYC_I    (WB_CYC_I),
  .WB_STB_I    (WB_STB_I),
  .WB_WE_I     (WB_WE_I),
  .WB_ADR_I    (WB_ADR_I),
  .WB_SEL_I    (WB_SEL_I),
  .WB_DAT_I    (WB_DAT_I),
  .WB_DAT_O    (WB_DAT_O),
  .WB_ACK_O    (WB_ACK_O),
  .SCK_O       (SCK_O),
  .SCK_OE      (SCK_OE),
  .MOSI_OE     (MOSI_OE),
  .MISO_OE     (MISO_OE),
  .EXT_IRQ_I   (EXT_IRQ_I),
  .IRQ_CHANNEL (IRQ_CHANNEL)
);

/* File: spimp_slave_model.sv */
// behavioural serial slave facing the port in master role
`timescale 1ns/1ps
module spimp_slave_model (
  // serial lines
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  output logic            miso,
  // mode and data
  input  wire logic       clock_idle_level,
  input  wire logic       capture_edge_select,
  input  wire logic [7:0] tx_byte,
  output logic [7:0]      rx_byte
);
  logic [7:0] sh = 8'h00;
  initial miso = 1'b0;
  initial rx_byte = 8'h00;
  // load on select, msb first
  always @(negedge sel_n) begin
    sh = tx_byte;
    miso = sh[7];
  end
  // released line shows the inverse
  always @(posedge sel_n) miso = ~miso;
  always @(sck) begin
    if (!sel_n) begin
      if ((sck != clock_idle_level) != capture_edge_select) begin
        rx_byte = {rx_byte[6:0], mosi};
      end else if (capture_edge_select) begin
        miso = sh[7];
        sh = {sh[6:0], 1'b0};
      end else begin
        sh = {sh[6:0], 1'b0};
        miso = sh[7];
      end
    end
  end
endmodule

/* File: spi_master_slave_port_test.sv */
// self-checking bench of the serial port with a slave partner
`timescale 1ns/1ps
`include "spimp_defines.svh"
module spi_master_slave_port_test;
  localparam logic [7:0] DR = `SPIMP_OFS_DATA;
  localparam logic [7:0] CR = `SPIMP_OFS_CTRL;
  localparam logic [7:0] SR = `SPIMP_OFS_STAT;
  localparam logic [7:0] PR = `SPIMP_OFS_PRSC;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        wen = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic        ext = 1'b0;
  logic        ss_n = 1'b1;
  logic        m_sck = 1'b0;
  logic        m_mosi = 1'b0;
  logic        p_sel_n = 1'b1;
  logic [7:0]  ctl = 8'h00;
  logic [7:0]  stx = 8'h00;
  logic [7:0]  pv, tx, half, q, mq, srx;
  logic [39:0] rows [4];
  logic [31:0] rdat;
  logic        ack, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, irq, p_miso;
  int          mismatches = 0;
  int          check_count = 0;
  int          c;
  wire sck_w = sck_oe ? sck_o : m_sck;
  wire mosi_w = mosi_oe ? mosi_o : m_mosi;
  wire miso_w = miso_oe ? miso_o : p_miso;
  always #5 clk = ~clk;
  spimp_top dut (.REF_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(wen), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE(sck_oe), .MOSI_I(mosi_w),
    .MOSI_O(mosi_o), .MOSI_OE(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o),
    .MISO_OE(miso_oe), .SS_N(ss_n), .EXT_IRQ_I(ext), .IRQ_CHANNEL(irq));
  spimp_slave_model peer (.sck(sck_w), .mosi(mosi_w), .sel_n(p_sel_n), .miso(p_miso),
    .clock_idle_level(ctl[3]), .capture_edge_select(ctl[2]), .tx_byte(stx), .rx_byte(srx));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input int w, input logic [7:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    sel <= 4'h1;
    wen <= w[0];
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
    @(posedge clk);
  endtask
  // wait for serial clock toggles, count the clock cycles taken, bounded
  task automatic toggles(input int e, input int cap, output int n);
    logic s;
    n = 0;
    s = sck_o;
    while (e > 0 && n < cap) begin
      @(posedge clk);
      n++;
      if (sck_o !== s) e--;
      s = sck_o;
    end
  endtask
  // bench as mode 0 master, half period 10 cycles
  task automatic mbyte(input logic [7:0] d);
    ss_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      m_mosi <= d[i];
      repeat (10) @(posedge clk);
      mq[i] = miso_w;
      m_sck <= 1'b1;
      repeat (10) @(posedge clk);
      m_sck <= 1'b0;
    end
    repeat (10) @(posedge clk);
    ss_n <= 1'b1;
    repeat (10) @(posedge clk);
  endtask
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #800000;
    mismatches++;
    complete_run();
  end
  initial begin
    rows = '{{8'h50, 8'h03, 8'ha5, 8'h3c, 8'd8}, {8'h5d, 8'h01, 8'h81, 8'h7e, 8'd8},
             {8'h56, 8'h12, 8'h5a, 8'hc3, 8'd24}, {8'h5b, 8'h01, 8'h01, 8'hfe, 8'd64}};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 5; a++) begin
      bus(0, DR + 8'(a), 8'h00);
      cmp(q, 8'h00);
    end
    for (int a = 2; a < 6; a += 2) begin
      bus(1, DR + 8'(a), 8'hff);
      bus(0, DR + 8'(a), 8'h00);
      cmp(q, 8'h00);
    end
    $display("reset test done");
    foreach (rows[i]) begin
      {ctl, pv, tx, stx, half} = rows[i];
      bus(1, CR, ctl);
      bus(1, PR, pv);
      bus(0, PR, 8'h00);
      cmp(q, pv & 8'h17);
      cmp(8'(sck_o), 8'(ctl[3]));
      p_sel_n <= 1'b0;
      @(posedge clk);
      bus(1, DR, tx);
      toggles(1, 6000, c);
      toggles(1, 6000, c);
      cmp(8'(c), half);
      toggles(14, 6000, c);
      repeat (4) @(posedge clk);
      p_sel_n <= 1'b1;
      bus(0, SR, 8'h00);
      cmp(q, 8'h80);
      bus(0, DR, 8'h00);
      cmp(q, stx);
      cmp(srx, tx);
      bus(0, SR, 8'h00);
      cmp(q, 8'h00);
      $display("row %0d test done", i);
    end
    p_sel_n <= 1'b0;
    @(posedge clk);
    bus(1, DR, 8'h11);
    bus(1, DR, 8'h22);
    toggles(16, 6000, c);
    repeat (4) @(posedge clk);
    bus(1, DR, 8'h44);
    toggles(1, 300, c);
    cmp(8'(c >= 300), 8'h01);
    bus(0, SR, 8'h00);
    cmp(q, 8'hc0);
    bus(0, DR, 8'h00);
    cmp(q, 8'hfe);
    cmp(srx, 8'h11);
    bus(0, SR, 8'h00);
    cmp(q, 8'h00);
    p_sel_n <= 1'b1;
    repeat (5100) @(posedge clk);
    cmp(8'(sck_o), 8'h01);
    $display("collision test done");
    bus(1, CR, 8'hf0);
    ss_n <= 1'b0;
    repeat (8) @(posedge clk);
    cmp(8'(irq), 8'h01);
    cmp(8'(sck_oe), 8'h00);
    bus(0, SR, 8'h00);
    cmp(q, 8'h10);
    bus(0, CR, 8'h00);
    cmp(q, 8'ha0);
    ss_n <= 1'b1;
    bus(1, CR, 8'ha0);
    bus(0, SR, 8'h00);
    cmp(q, 8'h00);
    cmp(8'(irq), 8'h00);
    bus(1, CR, 8'h20);
    ext <= 1'b1;
    repeat (8) @(posedge clk);
    cmp(8'(irq), 8'h00);
    bus(1, CR, 8'h00);
    repeat (4) @(posedge clk);
    cmp(8'(irq), 8'h01);
    ext <= 1'b0;
    $display("fault test done");
    bus(1, CR, 8'h43);
    bus(1, DR, 8'ha5);
    mbyte(8'h3c);
    cmp(mq, 8'ha5);
    mbyte(8'h77);
    cmp(mq, 8'h3c);
    bus(0, SR, 8'h00);
    cmp(q, 8'h80);
    bus(0, DR, 8'h00);
    cmp(q, 8'h3c);
    $display("slave test done");
    complete_run();
  end
endmodule
